//--- hdl/ucr_pkg.sv
package ucr_pkg;

  // ****************************************************
  // Line timing
  // ****************************************************
  localparam int CLK_HZ      = 20_000_000;
  localparam int BAUD_BPS    = 9600;
  localparam int OVERSAMPLE  = 16;
  localparam int OS_DIV      = CLK_HZ / (BAUD_BPS * OVERSAMPLE);
  localparam int OS_MID      = OVERSAMPLE / 2 - 1;
  localparam int DATA_BITS   = 8;
  localparam int FRAME_BITS  = 11;
  localparam int REPLY_LEN   = 4;
  localparam int BUF_DEPTH   = 2;
  localparam logic LINE_IDLE = 1'b1;

  // ****************************************************
  // Characters
  // ****************************************************
  localparam logic [7:0] CHAR_UPPER_T = 8'h54;
  localparam logic [7:0] CHAR_LOWER_T = 8'h74;
  localparam logic [7:0] BYTE_UP_O    = 8'h4f;
  localparam logic [7:0] BYTE_UP_K    = 8'h4b;
  localparam logic [7:0] BYTE_LO_O    = 8'h6f;
  localparam logic [7:0] BYTE_LO_K    = 8'h6b;
  localparam logic [7:0] BYTE_U       = 8'h55;
  localparam logic [7:0] BYTE_C       = 8'h43;
  localparam logic [7:0] BYTE_P       = 8'h50;
  localparam logic [7:0] BYTE_F       = 8'h46;
  localparam logic [7:0] BYTE_E       = 8'h45;
  localparam logic [7:0] BYTE_CR      = 8'h0d;
  localparam logic [7:0] BYTE_LF      = 8'h0a;

  // ****************************************************
  // Reply kinds
  // ****************************************************
  typedef enum logic [2:0] {
    REPLY_OK_UPPER = 3'b000,
    REPLY_OK_LOWER = 3'b001,
    REPLY_UNKNOWN  = 3'b010,
    REPLY_PARITY   = 3'b011,
    REPLY_FRAMING  = 3'b100,
    REPLY_OVERRUN  = 3'b101
  } ucr_reply_t;

endpackage

//--- hdl/ucr_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ucr_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- hdl/ucr_buffer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// Small FIFO between reply generator and transmitter
// ****************************************************
module ucr_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic     clk,
  input  wire logic     rst,
  ucr_stream_if.sink    in_s,
  ucr_stream_if.source  out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic          push;
  logic          pop;

  assign in_s.ready  = (count != CW'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

//--- hdl/ucr_responder.sv
// Summary of operation
// - Eight data bits per frame, both directions
// - Data bits travel least significant first
// - Even parity sent and checked
// - Both lines run at 9600 bps
// - Receive line non-inverted, idle high
// - Received 54h answers 4fh 4bh
// - Received 74h answers 6fh 6bh
// - Other characters answer 55h 43h
// - Every reply ends with CR, LF
// - Parity error answers 50h 45h
// - Framing error answers 46h 45h
// - Overrun error answers 4fh 45h
// - Separate receive, transmit and error events
// - Receive events outrank transmit-done handling
// - Capture received byte, then send reply
// - Return idle after whole reply sent
// - Separate transmit and receive channels, full duplex
`timescale 1ns/100ps
`default_nettype none
module ucr_responder #(
  parameter int OS_DIV = ucr_pkg::OS_DIV
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       serial_in_line,
  output logic            serial_out_line,
  output logic            rx_done_event,
  output logic            tx_done_event,
  output logic            rx_error_event,
  output logic [7:0]      rx_data,
  output logic            reply_busy
);
  localparam int DW = $clog2(OS_DIV);

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } ucr_rx_state_t;

  typedef enum logic [1:0] {
    RP_IDLE  = 2'b00,
    RP_LOAD  = 2'b01,
    RP_DRAIN = 2'b10
  } ucr_rp_state_t;

  function automatic logic [7:0] reply_byte(input ucr_pkg::ucr_reply_t k,
                                            input logic [1:0] i);
    logic [7:0] first;
    logic [7:0] second;
    first  = ucr_pkg::BYTE_U;
    second = ucr_pkg::BYTE_E;
    case (k)
      ucr_pkg::REPLY_OK_UPPER: begin
        first  = ucr_pkg::BYTE_UP_O;
        second = ucr_pkg::BYTE_UP_K;
      end
      ucr_pkg::REPLY_OK_LOWER: begin
        first  = ucr_pkg::BYTE_LO_O;
        second = ucr_pkg::BYTE_LO_K;
      end
      ucr_pkg::REPLY_UNKNOWN: begin
        first  = ucr_pkg::BYTE_U;
        second = ucr_pkg::BYTE_C;
      end
      ucr_pkg::REPLY_PARITY:  first = ucr_pkg::BYTE_P;
      ucr_pkg::REPLY_FRAMING: first = ucr_pkg::BYTE_F;
      ucr_pkg::REPLY_OVERRUN: first = ucr_pkg::BYTE_UP_O;
      default:                first = ucr_pkg::BYTE_U;
    endcase
    case (i)
      2'd0:    reply_byte = first;
      2'd1:    reply_byte = second;
      2'd2:    reply_byte = ucr_pkg::BYTE_CR;
      default: reply_byte = ucr_pkg::BYTE_LF;
    endcase
  endfunction

  // ****************************************************
  // Oversample divider
  // ****************************************************
  logic [DW-1:0] div;
  logic [DW-1:0] next_div;
  logic          tick;

  assign tick = (div == DW'(OS_DIV - 1));

  always_comb begin
    next_div = tick ? '0 : div + 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end

  // ****************************************************
  // Receive channel
  // ****************************************************
  logic          rx_meta;
  logic          rx_line;
  logic          rx_prev;
  ucr_rx_state_t rx_state;
  ucr_rx_state_t next_rx_state;
  logic [3:0]    rx_os;
  logic [3:0]    next_rx_os;
  logic [2:0]    rx_bit;
  logic [2:0]    next_rx_bit;
  logic [7:0]    rx_shift;
  logic [7:0]    next_rx_shift;
  logic          rx_par;
  logic          next_rx_par;
  logic          rx_end;
  logic          next_rx_end;
  logic          rx_pe;
  logic          next_rx_pe;
  logic          rx_fe;
  logic          next_rx_fe;
  logic          os_last;

  assign os_last = (rx_os == 4'(ucr_pkg::OVERSAMPLE - 1));

  always_comb begin
    next_rx_state = rx_state;
    next_rx_os    = rx_os;
    next_rx_bit   = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_par   = rx_par;
    next_rx_end   = 1'b0;
    next_rx_pe    = rx_pe;
    next_rx_fe    = rx_fe;
    case (rx_state)
      RX_IDLE: begin
        if (rx_prev && !rx_line) begin
          next_rx_state = RX_START;
          next_rx_os    = '0;
        end
      end
      RX_START: begin
        if (tick) begin
          next_rx_os = rx_os + 1'b1;
          if (rx_os == 4'(ucr_pkg::OS_MID)) begin
            next_rx_os    = '0;
            next_rx_bit   = '0;
            next_rx_state = rx_line ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_rx_os = rx_os + 1'b1;
          if (os_last) begin
            next_rx_shift = {rx_line, rx_shift[7:1]};
            next_rx_bit   = rx_bit + 1'b1;
            if (rx_bit == 3'(ucr_pkg::DATA_BITS - 1)) begin
              next_rx_state = RX_PARITY;
            end
          end
        end
      end
      RX_PARITY: begin
        if (tick) begin
          next_rx_os = rx_os + 1'b1;
          if (os_last) begin
            next_rx_par   = rx_line;
            next_rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          next_rx_os = rx_os + 1'b1;
          if (os_last) begin
            next_rx_end   = 1'b1;
            next_rx_pe    = ^{rx_shift, rx_par};
            next_rx_fe    = (rx_line != ucr_pkg::LINE_IDLE);
            next_rx_state = RX_IDLE;
          end
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta  <= 1'b1;
      rx_line  <= 1'b1;
      rx_prev  <= 1'b1;
      rx_state <= RX_IDLE;
      rx_os    <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_par   <= 1'b0;
      rx_end   <= 1'b0;
      rx_pe    <= 1'b0;
      rx_fe    <= 1'b0;
    end else begin
      rx_meta  <= serial_in_line;
      rx_line  <= rx_meta;
      rx_prev  <= rx_line;
      rx_state <= next_rx_state;
      rx_os    <= next_rx_os;
      rx_bit   <= next_rx_bit;
      rx_shift <= next_rx_shift;
      rx_par   <= next_rx_par;
      rx_end   <= next_rx_end;
      rx_pe    <= next_rx_pe;
      rx_fe    <= next_rx_fe;
    end
  end

  // ****************************************************
  // Event classification and reply sequencing
  // ****************************************************
  ucr_stream_if #(.W(8)) gen_s ();
  ucr_stream_if #(.W(8)) tx_s ();

  ucr_pkg::ucr_reply_t pend_kind;
  ucr_pkg::ucr_reply_t next_pend_kind;
  ucr_pkg::ucr_reply_t kind;
  ucr_pkg::ucr_reply_t next_kind;
  ucr_rp_state_t       rp_state;
  ucr_rp_state_t       next_rp_state;
  logic                pend;
  logic                next_pend;
  logic [1:0]          idx;
  logic [1:0]          next_idx;
  logic [2:0]          sent;
  logic [2:0]          next_sent;
  logic [7:0]          next_rx_data;
  logic                next_rx_done;
  logic                next_rx_err;
  logic                overrun;
  logic                take;
  logic                tx_done;

  assign overrun     = rx_end & pend & (rp_state != RP_IDLE);
  assign take        = (rp_state == RP_IDLE) & pend;
  assign gen_s.valid = (rp_state == RP_LOAD);
  assign gen_s.data  = reply_byte(kind, idx);

  always_comb begin
    next_pend      = pend & ~take;
    next_pend_kind = pend_kind;
    next_rx_data   = rx_data;
    next_rx_done   = 1'b0;
    next_rx_err    = 1'b0;
    // Receive side is served first, whatever the transmitter does
    if (rx_end) begin
      next_pend = 1'b1;                                               // set wins over take
      if (overrun) begin
        next_pend_kind = ucr_pkg::REPLY_OVERRUN;
      end else if (rx_fe) begin
        next_pend_kind = ucr_pkg::REPLY_FRAMING;
      end else if (rx_pe) begin
        next_pend_kind = ucr_pkg::REPLY_PARITY;
      end else if (rx_shift == ucr_pkg::CHAR_UPPER_T) begin
        next_pend_kind = ucr_pkg::REPLY_OK_UPPER;
      end else if (rx_shift == ucr_pkg::CHAR_LOWER_T) begin
        next_pend_kind = ucr_pkg::REPLY_OK_LOWER;
      end else begin
        next_pend_kind = ucr_pkg::REPLY_UNKNOWN;
      end
      if (overrun || rx_fe || rx_pe) begin
        next_rx_err = 1'b1;
      end else begin
        next_rx_done = 1'b1;
        next_rx_data = rx_shift;
      end
    end
  end

  always_comb begin
    next_rp_state = rp_state;
    next_kind     = kind;
    next_idx      = idx;
    next_sent     = sent + {2'b00, tx_done};
    case (rp_state)
      RP_IDLE: begin
        next_sent = '0;
        if (pend) begin
          next_kind     = pend_kind;
          next_idx      = '0;
          next_rp_state = RP_LOAD;
        end
      end
      RP_LOAD: begin
        if (gen_s.ready) begin
          next_idx = idx + 1'b1;
          if (idx == 2'(ucr_pkg::REPLY_LEN - 1)) begin
            next_rp_state = RP_DRAIN;
          end
        end
      end
      RP_DRAIN: begin
        if (sent == 3'(ucr_pkg::REPLY_LEN)) begin
          next_rp_state = RP_IDLE;
        end
      end
      default: next_rp_state = RP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend           <= 1'b0;
      pend_kind      <= ucr_pkg::REPLY_UNKNOWN;
      kind           <= ucr_pkg::REPLY_UNKNOWN;
      rp_state       <= RP_IDLE;
      idx            <= '0;
      sent           <= '0;
      rx_data        <= '0;
      rx_done_event  <= 1'b0;
      rx_error_event <= 1'b0;
      reply_busy     <= 1'b0;
    end else begin
      pend           <= next_pend;
      pend_kind      <= next_pend_kind;
      kind           <= next_kind;
      rp_state       <= next_rp_state;
      idx            <= next_idx;
      sent           <= next_sent;
      rx_data        <= next_rx_data;
      rx_done_event  <= next_rx_done;
      rx_error_event <= next_rx_err;
      reply_busy     <= (next_rp_state != RP_IDLE);
    end
  end

  ucr_buffer #(
    .W     (8),
    .DEPTH (ucr_pkg::BUF_DEPTH)
  ) u_buffer (
    .clk   (clk),
    .rst   (rst),
    .in_s  (gen_s.sink),
    .out_s (tx_s.source)
  );

  // ****************************************************
  // Transmit channel
  // ****************************************************
  logic       tx_busy;
  logic       next_tx_busy;
  logic [9:0] tx_shift;
  logic [9:0] next_tx_shift;
  logic [3:0] tx_os;
  logic [3:0] next_tx_os;
  logic [3:0] tx_cnt;
  logic [3:0] next_tx_cnt;
  logic       next_line;
  logic       next_tx_done;

  assign tx_s.ready    = ~tx_busy;
  assign tx_done_event = tx_done;

  always_comb begin
    next_tx_busy  = tx_busy;
    next_tx_shift = tx_shift;
    next_tx_os    = tx_os;
    next_tx_cnt   = tx_cnt;
    next_line     = serial_out_line;
    next_tx_done  = 1'b0;
    if (!tx_busy) begin
      if (tx_s.valid) begin
        next_tx_busy  = 1'b1;
        next_tx_shift = {1'b1, ^tx_s.data, tx_s.data};
        next_tx_os    = '0;
        next_tx_cnt   = '0;
        next_line     = 1'b0;
      end
    end else if (tick) begin
      next_tx_os = tx_os + 1'b1;
      if (tx_os == 4'(ucr_pkg::OVERSAMPLE - 1)) begin
        if (tx_cnt == 4'(ucr_pkg::FRAME_BITS - 1)) begin
          next_tx_busy = 1'b0;
          next_line    = ucr_pkg::LINE_IDLE;
          next_tx_done = 1'b1;
        end else begin
          next_line     = tx_shift[0];
          next_tx_shift = {1'b1, tx_shift[9:1]};
          next_tx_cnt   = tx_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_busy         <= 1'b0;
      tx_shift        <= '1;
      tx_os           <= '0;
      tx_cnt          <= '0;
      serial_out_line <= 1'b1;
      tx_done         <= 1'b0;
    end else begin
      tx_busy         <= next_tx_busy;
      tx_shift        <= next_tx_shift;
      tx_os           <= next_tx_os;
      tx_cnt          <= next_tx_cnt;
      serial_out_line <= next_line;
      tx_done         <= next_tx_done;
    end
  end
endmodule
`default_nettype wire

//--- verification/ucr_responder_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// Port checker for the character responder
// ****************************************************
module ucr_responder_chk #(
  parameter int OS_DIV = ucr_pkg::OS_DIV
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       serial_in_line,
  input wire logic       serial_out_line,
  input wire logic       rx_done_event,
  input wire logic       tx_done_event,
  input wire logic       rx_error_event,
  input wire logic [7:0] rx_data,
  input wire logic       reply_busy
);
  // Shortest legal low run and frame, allowing the short first bit
  localparam int BIT       = OS_DIV * ucr_pkg::OVERSAMPLE;
  localparam int MIN_BIT   = BIT - OS_DIV;
  localparam int MIN_FRAME = ucr_pkg::FRAME_BITS * BIT - OS_DIV;

  logic [15:0] low_run;
  logic [15:0] next_low_run;
  logic [15:0] gap;
  logic [15:0] next_gap;
  logic [2:0]  ntx;
  logic [2:0]  next_ntx;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************************
  // Helper counters
  // ****************************************************
  always_comb begin
    next_low_run = serial_out_line ? 16'h0000 : low_run + 16'h0001;
    next_gap     = tx_done_event ? 16'h0000 : ((gap == 16'hffff) ? gap : gap + 16'h0001);
    next_ntx     = reply_busy ? ntx + {2'b00, tx_done_event} : 3'h0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_run <= 16'h0000;
      gap     <= 16'h0000;
      ntx     <= 3'h0;
    end else begin
      low_run <= next_low_run;
      gap     <= next_gap;
      ntx     <= next_ntx;
    end
  end

  // ****************************************************
  // Sequences and properties
  // ****************************************************
  sequence s_start_bit;
    ##[1:10] !serial_out_line;
  endsequence

  sequence s_busy_end;
    $past(tx_done_event, 2) && (ntx[1:0] == 2'b00) && (ntx != 3'h0);
  endsequence

  property p_idle_high;
    !reply_busy |-> serial_out_line;
  endproperty
  property p_evt_excl;
    !(rx_done_event && rx_error_event);
  endproperty
  property p_rx_pulse;
    rx_done_event |=> !rx_done_event;
  endproperty
  property p_err_pulse;
    rx_error_event |=> !rx_error_event;
  endproperty
  property p_data_update;
    $changed(rx_data) |-> rx_done_event;
  endproperty
  property p_reply_follows;
    (rx_done_event || rx_error_event) |=> reply_busy;
  endproperty
  property p_start_soon;
    $rose(reply_busy) |-> s_start_bit;
  endproperty
  property p_bit_time;
    $rose(serial_out_line) |-> (low_run >= MIN_BIT);
  endproperty
  property p_frame_len;
    tx_done_event |-> (gap >= MIN_FRAME);
  endproperty
  property p_stop_high;
    tx_done_event |-> $past(serial_out_line);
  endproperty
  property p_busy_end;
    $fell(reply_busy) |-> s_busy_end;
  endproperty

  a_idle_high: assert property (p_idle_high) else $error("line low while idle");
  a_evt_excl: assert property (p_evt_excl) else $error("done and error together");
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx done not a pulse");
  a_err_pulse: assert property (p_err_pulse) else $error("rx error not a pulse");
  a_data_update: assert property (p_data_update) else $error("rx data moved alone");
  a_reply_follows: assert property (p_reply_follows) else $error("no reply busy");
  a_start_soon: assert property (p_start_soon) else $error("reply start late");
  a_bit_time: assert property (p_bit_time) else $error("low run too short");
  a_frame_len: assert property (p_frame_len) else $error("frame too short");
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");
  a_busy_end: assert property (p_busy_end) else $error("reply not four frames");
endmodule
`default_nettype wire

//--- verification/ucr_remote_station.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// Remote station: sends characters, decodes replies
// ****************************************************
module ucr_remote_station #(
  parameter int OS_DIV = ucr_pkg::OS_DIV
) (
  input  wire logic clk,
  input  wire logic serial_out_line,
  output var logic  serial_in_line
);
  localparam int BIT = OS_DIV * ucr_pkg::OVERSAMPLE;

  logic [7:0] got_q[$];
  int         frame_errs = 0;

  initial serial_in_line = ucr_pkg::LINE_IDLE;

  task automatic send_char(input logic [7:0] ch, input logic bad_par, input logic bad_stop,
                           input int idle_bits);
    logic [10:0] fr;
    fr = {~bad_stop, (^ch) ^ bad_par, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      serial_in_line <= fr[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    serial_in_line <= ucr_pkg::LINE_IDLE;
    repeat (idle_bits * BIT - 1) @(posedge clk);
  endtask

  // Replies sampled mid-bit from the start edge
  initial begin : rx_loop
    logic [7:0] b;
    logic       p;
    logic       s;
    forever begin
      @(negedge clk);
      if (serial_out_line === 1'b0) begin
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(negedge clk);
          b[i] = serial_out_line;
        end
        repeat (BIT) @(negedge clk);
        p = serial_out_line;
        repeat (BIT) @(negedge clk);
        s = serial_out_line;
        got_q.push_back(b);
        if (p !== ^b) frame_errs++;
        if (s !== 1'b1) frame_errs++;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/uart_char_responder_test.sv
`timescale 1ns/100ps
`default_nettype none
module uart_char_responder_test;
  // Fast divider keeps the run short; all line timing scales with it
  localparam int DIV        = 4;
  localparam int BIT        = DIV * ucr_pkg::OVERSAMPLE;
  localparam int REPLY_WAIT = 60 * BIT;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       serial_in_line;
  logic       serial_out_line;
  logic       rx_done_event;
  logic       tx_done_event;
  logic       rx_error_event;
  logic [7:0] rx_data;
  logic       reply_busy;
  int         num_errors = 0;
  int         n_compared = 0;
  int         n_rxd = 0;
  int         n_rxe = 0;
  int         n_txd = 0;
  int         d0;
  int         e0;
  int         t0;

  always #25 clk = ~clk;

  always @(negedge clk) begin
    if (rx_done_event === 1'b1) n_rxd <= n_rxd + 1;
    if (rx_error_event === 1'b1) n_rxe <= n_rxe + 1;
    if (tx_done_event === 1'b1) n_txd <= n_txd + 1;
  end

  ucr_responder #(.OS_DIV(DIV)) dut_u (
    .clk             (clk),
    .rst             (rst),
    .serial_in_line  (serial_in_line),
    .serial_out_line (serial_out_line),
    .rx_done_event   (rx_done_event),
    .tx_done_event   (tx_done_event),
    .rx_error_event  (rx_error_event),
    .rx_data         (rx_data),
    .reply_busy      (reply_busy)
  );

  ucr_remote_station #(.OS_DIV(DIV)) st_u (
    .clk             (clk),
    .serial_out_line (serial_out_line),
    .serial_in_line  (serial_in_line)
  );

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fail_wait();
    num_errors++;
    $display("ERROR t=%0t wait bound used up", $time);
    summarize();
  endtask

  task automatic snap();
    d0 = n_rxd;
    e0 = n_rxe;
    t0 = n_txd;
  endtask

  task automatic ev_check(input logic [7:0] rxd, input logic [7:0] rxe, input logic [7:0] txd);
    check(8'(n_rxd - d0), rxd);
    check(8'(n_rxe - e0), rxe);
    check(8'(n_txd - t0), txd);
  endtask

  task automatic get_reply(input logic [7:0] b0, input logic [7:0] b1);
    int n;
    n = 0;
    while (st_u.got_q.size() < 4 && n < REPLY_WAIT) begin
      @(negedge clk);
      n++;
    end
    if (n == REPLY_WAIT) fail_wait();
    check(st_u.got_q.pop_front(), b0);
    check(st_u.got_q.pop_front(), b1);
    check(st_u.got_q.pop_front(), 8'h0d);
    check(st_u.got_q.pop_front(), 8'h0a);
    check(8'(st_u.frame_errs), 8'h00);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (reply_busy !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n == 4000) fail_wait();
  endtask

  task automatic run_case(input logic [7:0] ch, input logic bp, input logic bs,
                          input logic [7:0] b0, input logic [7:0] b1);
    snap();
    st_u.send_char(ch, bp, bs, 2);
    get_reply(b0, b1);
    wait_idle();
    if (bp || bs) ev_check(8'h00, 8'h01, 8'h04);
    else ev_check(8'h01, 8'h00, 8'h04);
    if (!(bp || bs)) check(rx_data, ch);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    check({7'h00, serial_out_line}, 8'h01);
    check({7'h00, reply_busy}, 8'h00);
    check(rx_data, 8'h00);
    run_case(8'h54, 1'b0, 1'b0, 8'h4f, 8'h4b);
    run_case(8'h74, 1'b0, 1'b0, 8'h6f, 8'h6b);
    run_case(8'h53, 1'b0, 1'b0, 8'h55, 8'h43);
    run_case(8'hf4, 1'b0, 1'b0, 8'h55, 8'h43);
    run_case(8'h54, 1'b1, 1'b0, 8'h50, 8'h45);
    run_case(8'h54, 1'b0, 1'b1, 8'h46, 8'h45);
    run_case(8'h74, 1'b1, 1'b1, 8'h46, 8'h45);
    snap();
    st_u.send_char(8'h54, 1'b0, 1'b0, 1);
    st_u.send_char(8'h78, 1'b0, 1'b0, 1);
    st_u.send_char(8'h79, 1'b0, 1'b0, 1);
    get_reply(8'h4f, 8'h4b);
    get_reply(8'h4f, 8'h45);
    wait_idle();
    ev_check(8'h02, 8'h01, 8'h08);
    summarize();
  end
endmodule

bind ucr_responder ucr_responder_chk #(.OS_DIV(OS_DIV)) chk_u (
  .clk             (clk),
  .rst             (rst),
  .serial_in_line  (serial_in_line),
  .serial_out_line (serial_out_line),
  .rx_done_event   (rx_done_event),
  .tx_done_event   (tx_done_event),
  .rx_error_event  (rx_error_event),
  .rx_data         (rx_data),
  .reply_busy      (reply_busy)
);
`default_nettype wire
